// ===== hdl/flash_command_sequencer.sv
`include "flash_host_cfg.svh"
`default_nettype none
module flash_command_sequencer
  import flash_host_pkg::*;
(
  // Clock, reset and enable.
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clock_en,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [31:0] o_reg_rdata,
  // Flash pins.
  output logic [20:0] o_flash_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe_n,
  input wire logic [15:0] i_dq_in,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic o_byte_n,
  output logic o_flash_reset_n,
  input wire logic i_ready_busy_out
);

  localparam int ACC_CYC = (`ACCESS_NS + `CLOCK_NS - 1) / `CLOCK_NS + 2;
  localparam int BUSY_CYC = (`BUSY_NS + `CLOCK_NS - 1) / `CLOCK_NS + 2;
  localparam int RST_CYC = (`RESET_PULSE_NS + `CLOCK_NS - 1) / `CLOCK_NS;
  localparam int RDY_CYC = (`RESET_READY_NS + `CLOCK_NS - 1) / `CLOCK_NS;

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_READ, S_RECOVER,
    S_HWRST, S_HWWAIT} state_t;

  state_t state_q;
  mode_t mode_q;
  op_t op_q;
  logic [2:0] step_q;
  logic [7:0] cnt_q;
  logic byte_mode_q;
  logic refused_q;
  logic [20:0] addr_q;
  logic [15:0] data_q;
  logic [15:0] rdata_q;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic rb_s1_q, rb_s2_q;
  cyc_t cur;
  logic start, hwrst_req, op_ok, done_busy;
  op_t new_op;

  // Unlock address for the given width; byte mode doubles the address.
  function automatic logic [20:0] unlock_addr(input logic first, input logic byte_m);
    if (byte_m)
      unlock_addr = first ? `UNLOCK1_BYTE : `UNLOCK2_BYTE;
    else
      unlock_addr = first ? `UNLOCK1_WORD : `UNLOCK2_WORD;
  endfunction

  // Bus cycle number st of an operation; command cycles other than the sector erase keep upper bits zero.
  function automatic cyc_t cycle_of(input op_t op, input logic [2:0] st,
                                    input logic bm, input logic [20:0] a,
                                    input logic [15:0] d);
    cyc_t c;
    logic [20:0] u1, u2;
    c = '{kind: K_END, addr: 21'h00_0000, data: 16'h0000};
    u1 = unlock_addr(1'b1, bm);
    u2 = unlock_addr(1'b0, bm);
    // Two unlock writes open every long sequence.
    if ((op == OP_ID || op == OP_PROG || op == OP_BYP_ENTER || op == OP_CHIP_ER
         || op == OP_SECT_ER) && st < 3'h2)
      c = '{kind: K_WRITE, addr: (st == 3'h0) ? u1 : u2,
            data: (st == 3'h0) ? `CODE_UNLOCK1 : `CODE_UNLOCK2};
    else
      unique case (op)
        OP_READ: if (st == 3'h0) c = '{kind: K_READ, addr: a, data: 16'h0000};
        OP_RESET: if (st == 3'h0) c = '{kind: K_WRITE, addr: u1, data: `CODE_RESET};
        OP_ID:
          if (st == 3'h2) c = '{kind: K_WRITE, addr: u1, data: `CODE_ID};
          else if (st == 3'h3) c = '{kind: K_READ, addr: a, data: 16'h0000};
        OP_PROG:
          if (st == 3'h2) c = '{kind: K_WRITE, addr: u1, data: `CODE_PROG};
          else if (st == 3'h3) c = '{kind: K_WRITE, addr: a, data: d};
        OP_BYP_ENTER:
          if (st == 3'h2) c = '{kind: K_WRITE, addr: u1, data: `CODE_BYPASS};
        OP_BYP_PROG:
          if (st == 3'h0) c = '{kind: K_WRITE, addr: u1, data: `CODE_PROG};
          else if (st == 3'h1) c = '{kind: K_WRITE, addr: a, data: d};
        OP_BYP_EXIT:
          if (st == 3'h0) c = '{kind: K_WRITE, addr: u1, data: `CODE_ID};
          else if (st == 3'h1) c = '{kind: K_WRITE, addr: u1, data: `CODE_BYP_EXIT};
        OP_CHIP_ER, OP_SECT_ER:
          if (st == 3'h2) c = '{kind: K_WRITE, addr: u1, data: `CODE_ERASE_SETUP};
          else if (st == 3'h3) c = '{kind: K_WRITE, addr: u1, data: `CODE_UNLOCK1};
          else if (st == 3'h4) c = '{kind: K_WRITE, addr: u2, data: `CODE_UNLOCK2};
          else if (st == 3'h5 && op == OP_CHIP_ER)
            c = '{kind: K_WRITE, addr: u1, data: `CODE_CHIP_ERASE};
          else if (st == 3'h5)
            c = '{kind: K_WRITE, addr: a, data: `CODE_SECT_ERASE};
        OP_SUSPEND: if (st == 3'h0) c = '{kind: K_WRITE, addr: u1, data: `CODE_SUSPEND};
        OP_RESUME: if (st == 3'h0) c = '{kind: K_WRITE, addr: u1, data: `CODE_RESUME};
        OP_CFI:
          if (st == 3'h0)
            c = '{kind: K_WRITE, addr: bm ? `CFI_ADDR_BYTE : `CFI_ADDR_WORD,
                  data: `CODE_CFI};
      endcase
    cycle_of = c;
  endfunction

  // Whether an operation may be issued in the present mode.
  function automatic logic allowed(input op_t op, input mode_t m);
    unique case (op)
      OP_READ: allowed = 1'b1;
      OP_RESET: allowed = (m != M_BYPASS) && (m != M_BYP_PROG);
      OP_ID: allowed = (m == M_READ) || (m == M_SUSP);
      OP_PROG: allowed = (m == M_READ) || (m == M_SUSP);
      OP_BYP_ENTER, OP_CHIP_ER, OP_SECT_ER: allowed = (m == M_READ);
      OP_BYP_PROG, OP_BYP_EXIT: allowed = (m == M_BYPASS);
      OP_SUSPEND: allowed = (m == M_SECT_ER);
      OP_RESUME: allowed = (m == M_SUSP);
      OP_CFI: allowed = (m == M_READ) || (m == M_ID);
    endcase
  endfunction

  assign cur = cycle_of(op_q, step_q, byte_mode_q, addr_q, data_q);
  assign new_op = op_t'(i_reg_wdata[3:0]);
  assign start = i_reg_write && i_reg_addr == `REG_CMD && state_q == S_IDLE
                 && i_reg_wdata[3:0] < `OP_COUNT;
  assign op_ok = start && allowed(new_op, mode_q);
  assign hwrst_req = i_reg_write && i_reg_addr == `REG_CTRL
                     && i_reg_wdata[`CTRL_HWRST_BIT];
  // Busy modes finish once ready/busy is seen high after the settle time.
  assign done_busy = state_q == S_IDLE && cnt_q == 8'h00 && rb_s2_q
                     && (mode_q == M_PROG || mode_q == M_BYP_PROG || mode_q == M_SUSP_PROG
                         || mode_q == M_CHIP_ER || mode_q == M_SECT_ER);

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
    begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end
    else if (i_clock_en)
    begin
      dq_s1_q <= i_dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= i_ready_busy_out;
      rb_s2_q <= rb_s1_q;
    end

  // Software settings and the refused flag; a refusal wins over its clear.
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
    begin
      byte_mode_q <= 1'b0;
      addr_q <= 21'h00_0000;
      data_q <= 16'h0000;
      refused_q <= 1'b0;
    end
    else if (i_clock_en)
    begin
      if (i_reg_write && i_reg_addr == `REG_CTRL && state_q == S_IDLE)
        byte_mode_q <= i_reg_wdata[`CTRL_BYTE_BIT];
      if (i_reg_write && i_reg_addr == `REG_ADDR)
        addr_q <= i_reg_wdata[20:0];
      if (i_reg_write && i_reg_addr == `REG_DATA)
        data_q <= i_reg_wdata[15:0];
      if (i_reg_write && i_reg_addr == `REG_CMD && !op_ok)
        refused_q <= 1'b1;
      else if (i_reg_write && i_reg_addr == `REG_STATUS
               && i_reg_wdata[`STAT_REFUSED_BIT])
        refused_q <= 1'b0;
    end

  // Cycle sequencer: setup, write strobe low, strobe high, recovery.
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
    begin
      state_q <= S_IDLE;
      op_q <= OP_READ;
      step_q <= 3'h0;
      cnt_q <= 8'h00;
      rdata_q <= 16'h0000;
    end
    else if (i_clock_en)
    begin
      unique case (state_q)
        S_IDLE:
          if (hwrst_req)
          begin
            // The pulse runs from the count down to zero inclusive, so load one less.
            state_q <= S_HWRST;
            cnt_q <= 8'(RST_CYC - 1);
          end
          else if (op_ok)
          begin
            op_q <= new_op;
            step_q <= 3'h0;
            state_q <= S_SETUP;
          end
          else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
        S_SETUP:
          if (cur.kind == K_END)
          begin
            state_q <= S_IDLE;
            cnt_q <= 8'(BUSY_CYC);
          end
          else if (cur.kind == K_READ)
          begin
            state_q <= S_READ;
            cnt_q <= 8'(ACC_CYC);
          end
          else
            state_q <= S_STROBE;
        S_STROBE: state_q <= S_HOLD;
        S_HOLD: state_q <= S_RECOVER;
        S_READ:
          if (cnt_q == 8'h00)
          begin
            rdata_q <= byte_mode_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
            state_q <= S_RECOVER;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        S_RECOVER:
        begin
          step_q <= step_q + 3'h1;
          state_q <= S_SETUP;
        end
        S_HWRST:
          if (cnt_q == 8'h00)
          begin
            state_q <= S_HWWAIT;
            cnt_q <= 8'(RDY_CYC);
          end
          else
            cnt_q <= cnt_q - 8'h01;
        S_HWWAIT:
          if (cnt_q == 8'h00)
            state_q <= S_IDLE;
          else
            cnt_q <= cnt_q - 8'h01;
      endcase
    end

  // Mode tracking follows accepted sequences and the ready/busy pin.
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      mode_q <= M_READ;
    else if (i_clock_en)
    begin
      if (state_q == S_HWRST)
        mode_q <= M_READ;
      else if (done_busy)
        mode_q <= (mode_q == M_BYP_PROG) ? M_BYPASS :
                  (mode_q == M_SUSP_PROG) ? M_SUSP : M_READ;
      else if (op_ok)
        unique case (new_op)
          OP_RESET: mode_q <= (mode_q == M_SUSP_ID || mode_q == M_SUSP
                               || mode_q == M_SUSP_PROG) ? M_SUSP : M_READ;
          OP_ID: mode_q <= (mode_q == M_SUSP) ? M_SUSP_ID : M_ID;
          OP_PROG: mode_q <= (mode_q == M_SUSP) ? M_SUSP_PROG : M_PROG;
          OP_BYP_ENTER: mode_q <= M_BYPASS;
          OP_BYP_PROG: mode_q <= M_BYP_PROG;
          OP_BYP_EXIT: mode_q <= M_READ;
          OP_CHIP_ER: mode_q <= M_CHIP_ER;
          OP_SECT_ER, OP_RESUME: mode_q <= M_SECT_ER;
          OP_SUSPEND: mode_q <= M_SUSP;
          OP_CFI: mode_q <= M_CFI;
          OP_READ: mode_q <= mode_q;
        endcase
    end

  // Flash pin registers; the data bus is driven only during write cycles.
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
    begin
      o_flash_addr <= 21'h00_0000;
      o_dq_out <= 16'h0000;
      o_dq_oe_n <= 1'b1;
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_flash_reset_n <= 1'b1;
    end
    else if (i_clock_en)
    begin
      o_flash_reset_n <= !(state_q == S_HWRST);
      o_flash_addr <= cur.addr;
      o_dq_out <= cur.data;
      o_dq_oe_n <= !((state_q == S_SETUP || state_q == S_STROBE) && cur.kind == K_WRITE);
      o_ce_n <= !(((state_q == S_SETUP || state_q == S_STROBE) && cur.kind != K_END)
                  || (state_q == S_READ && cnt_q != 8'h00));
      o_we_n <= !(state_q == S_SETUP && cur.kind == K_WRITE);
      o_oe_n <= !((state_q == S_SETUP && cur.kind == K_READ)
                  || (state_q == S_READ && cnt_q != 8'h00));
    end

  assign o_byte_n = !byte_mode_q;

  // Read data answer, one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      o_reg_rdata <= 32'h0000_0000;
    else if (i_clock_en)
    begin
      o_reg_rdata <= 32'h0000_0000;
      if (i_reg_read)
        unique case (i_reg_addr)
          `REG_CTRL: o_reg_rdata <= {31'h0000_0000, byte_mode_q};
          `REG_ADDR: o_reg_rdata <= {11'h000, addr_q};
          `REG_DATA: o_reg_rdata <= {16'h0000, data_q};
          `REG_STATUS: o_reg_rdata <= {24'h00_0000, mode_q, 1'b0, refused_q, rb_s2_q,
                                       state_q != S_IDLE};
          `REG_RDATA: o_reg_rdata <= {16'h0000, rdata_q};
          default: o_reg_rdata <= 32'h0000_0000;
        endcase
    end

endmodule
`default_nettype wire

// ===== hdl/flash_host_cfg.svh
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// Register offsets of the controller's own register file.
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_CMD 8'h0C
`define REG_STATUS 8'h10
`define REG_RDATA 8'h14

// Field positions.
`define CTRL_BYTE_BIT 0
`define CTRL_HWRST_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_RB_BIT 1
`define STAT_REFUSED_BIT 2
`define STAT_MODE_LSB 4
`define OP_COUNT 4'hC

// Command sequence addresses and codes.
`define UNLOCK1_WORD 21'h00_0555
`define UNLOCK2_WORD 21'h00_02AA
`define UNLOCK1_BYTE 21'h00_0AAA
`define UNLOCK2_BYTE 21'h00_0555
`define CFI_ADDR_WORD 21'h00_0055
`define CFI_ADDR_BYTE 21'h00_00AA
`define CODE_UNLOCK1 16'h00AA
`define CODE_UNLOCK2 16'h0055
`define CODE_ID 16'h0090
`define CODE_PROG 16'h00A0
`define CODE_BYPASS 16'h0020
`define CODE_BYP_EXIT 16'h0000
`define CODE_ERASE_SETUP 16'h0080
`define CODE_CHIP_ERASE 16'h0010
`define CODE_SECT_ERASE 16'h0030
`define CODE_SUSPEND 16'h00B0
`define CODE_RESUME 16'h0030
`define CODE_RESET 16'h00F0
`define CODE_CFI 16'h0098

// Timing, in ns, and the clock period.
`define CLOCK_NS 100
`define ACCESS_NS 120
`define BUSY_NS 90
`define RESET_PULSE_NS 500
`define RESET_READY_NS 20000

`endif

// ===== hdl/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;

  // Operations that software may start, in the order of their command codes.
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_ID, OP_PROG, OP_BYP_ENTER, OP_BYP_PROG,
    OP_BYP_EXIT, OP_CHIP_ER, OP_SECT_ER, OP_SUSPEND, OP_RESUME, OP_CFI
  } op_t;

  // Mode of the flash as tracked by the controller.
  typedef enum logic [3:0] {
    M_READ, M_ID, M_CFI, M_BYPASS, M_PROG, M_BYP_PROG, M_CHIP_ER,
    M_SECT_ER, M_SUSP, M_SUSP_ID, M_SUSP_PROG
  } mode_t;

  typedef enum logic [1:0] {K_WRITE, K_READ, K_END} kind_t;

  // One bus cycle towards the flash.
  typedef struct packed {
    kind_t kind;
    logic [20:0] addr;
    logic [15:0] data;
  } cyc_t;

endpackage
`default_nettype wire

// ===== test/flash_command_sequencer_asserts.sv
`default_nettype none
module flash_command_sequencer_asserts (
  // Clock, reset and register port.
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_reg_read,
  input wire logic [31:0] o_reg_rdata,
  // Flash pins.
  input wire logic [20:0] o_flash_addr,
  input wire logic [15:0] o_dq_out,
  input wire logic o_dq_oe_n,
  input wire logic o_ce_n,
  input wire logic o_we_n,
  input wire logic o_oe_n,
  input wire logic o_byte_n,
  input wire logic o_flash_reset_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Write pulses sit inside select with the data driven and held past the rise.
  AST_WE_IN_CE: assert property (!o_we_n |-> !o_ce_n && !o_dq_oe_n)
    else $error("write strobe outside select");
  AST_WE_HOLD: assert property ($fell(o_we_n) |=> o_we_n && !o_ce_n &&
    $stable(o_flash_addr) && $stable(o_dq_out)) else $error("write cycle not held");
  AST_NO_FIGHT: assert property (!o_oe_n |-> o_dq_oe_n && o_we_n)
    else $error("bus driven during read");
  AST_CE_IDLE: assert property (o_ce_n |-> o_we_n && o_oe_n)
    else $error("strobe without select");
  AST_DQ_REL: assert property ($rose(o_ce_n) |-> o_dq_oe_n)
    else $error("bus kept after select");
  AST_READ_LEN: assert property ($fell(o_oe_n) |-> (!o_oe_n && !o_ce_n)[*5] ##1 o_oe_n)
    else $error("read cycle length wrong");
  AST_RST_PULSE: assert property ($fell(o_flash_reset_n) |->
    !o_flash_reset_n[*5] ##1 o_flash_reset_n) else $error("reset pulse length wrong");
  AST_RDATA_ONCE: assert property (!$past(i_reg_read) |-> o_reg_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  AST_BYTE_IDLE: assert property ($changed(o_byte_n) |-> o_ce_n && $past(o_ce_n))
    else $error("width changed in a cycle");
  C_WRITE: cover property ($fell(o_we_n));
  C_READ: cover property ($fell(o_oe_n));
  C_RESET: cover property ($fell(o_flash_reset_n));
endmodule
bind flash_command_sequencer flash_command_sequencer_asserts u_chk (.i_clock, .i_resetn,
  .i_reg_read, .o_reg_rdata, .o_flash_addr, .o_dq_out, .o_dq_oe_n, .o_ce_n, .o_we_n,
  .o_oe_n, .o_byte_n, .o_flash_reset_n);
`default_nettype wire

// ===== test/flash_dev_model.sv
`default_nettype none
module flash_dev_model #(
  parameter logic [15:0] MFR_CODE = 16'h005A, // Arbitrary value.
  parameter logic [15:0] DEV_CODE = 16'h00A7 // Arbitrary value.
) (
  // Bus pins as the device sees them.
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_byte_n,
  input wire logic i_reset_n,
  // Device answers.
  output logic [15:0] o_dq,
  output logic o_rb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  logic [36:0] log_q [$];
  logic [20:0] la_q;
  logic [15:0] rv, rv_q;
  logic id_q, byp_q, pgm_q, wr_q;
  int step;
  // Every cell starts erased, so a program can only clear bits.
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {id_q, byp_q, pgm_q, wr_q} = 4'h0;
    step = 0;
    rv_q = 16'h0000;
    o_rb = 1'b1;
  end
  // Command decoder; a write that breaks a sequence drops back to step zero.
  task automatic take(input logic [20:0] a, input logic [15:0] d);
    logic [10:0] u1;
    logic [10:0] u2;
    u1 = i_byte_n ? 11'h555 : 11'hAAA;
    u2 = i_byte_n ? 11'h2AA : 11'h555;
    log_q.push_back({a, d});
    if (!o_rb) return;
    if (pgm_q)
    begin
      mem[a[7:0]] &= d;
      pgm_q = 1'b0;
      o_rb = 1'b0;
      o_rb <= #3000 1'b1;
    end
    else if (d[7:0] == 8'hF0)
    begin
      id_q = 1'b0;
      step = 0;
    end
    else if (step == 9)
    begin
      byp_q = (d[7:0] != 8'h00);
      step = 0;
    end
    else if (byp_q)
    begin
      pgm_q = (d[7:0] == 8'hA0);
      step = (d[7:0] == 8'h90) ? 9 : 0;
    end
    else if (step == 0 || step == 3)
      step = (a[10:0] == u1 && d[7:0] == 8'hAA) ? step + 1 : 0;
    else if (step == 1 || step == 4)
      step = (a[10:0] == u2 && d[7:0] == 8'h55) ? step + 1 : 0;
    else
    begin
      id_q = (step == 2 && d[7:0] == 8'h90);
      pgm_q = (step == 2 && d[7:0] == 8'hA0);
      byp_q = (step == 2 && d[7:0] == 8'h20);
      step = (step == 2 && d[7:0] == 8'h80) ? 3 : 0;
    end
  endtask
  // Address latches on the later falling strobe.
  always @(negedge i_ce_n or negedge i_we_n)
    if (!i_ce_n && !i_we_n)
    begin
      // The controller moves address and strobe on one edge; let the address settle.
      #1;
      la_q = i_addr;
      wr_q = 1'b1;
    end
  // Data latches on the first rising strobe.
  always @(posedge i_ce_n or posedge i_we_n)
    if (wr_q)
    begin
      wr_q = 1'b0;
      take(la_q, i_dq);
    end
  // A hardware reset abandons any mode at once.
  always @(negedge i_reset_n)
  begin
    {id_q, byp_q, pgm_q} = 3'h0;
    step = 0;
  end
  // A released bus shows the inverse of the last data so stale values never match.
  assign rv = !id_q ? mem[i_addr[7:0]] : (i_addr[7:0] == 8'h00) ? MFR_CODE :
    (i_addr[7:0] == 8'h01) ? DEV_CODE : 16'h0000;
  always @(posedge i_oe_n) rv_q = rv;
  assign o_dq = (!i_ce_n && !i_oe_n) ? rv : ~rv_q;
endmodule
`default_nettype wire

// ===== test/tb_flash_command_sequencer.sv
`include "flash_host_cfg.svh"
`default_nettype none
module tb_flash_command_sequencer
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MFR = 16'h005A; // Arbitrary value.
  localparam logic [15:0] DEV = 16'h00A7; // Arbitrary value.
  logic i_clock = 1'b0, i_resetn = 1'b0, rw = 1'b0, rr = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd, v;
  logic [20:0] fa;
  logic [15:0] dqo, dqm, dqw;
  logic dq_oe_n, ce_n, we_n, oe_n, byte_n, frst_n, rb;
  int err_count = 0, n_checks = 0, cyc = 0;
  // The wire carries our data while we drive it, the device's otherwise.
  assign dqw = !dq_oe_n ? dqo : dqm;
  flash_command_sequencer dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_clock_en(1'b1),
    .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_write(rw), .i_reg_read(rr), .o_reg_rdata(rd),
    .o_flash_addr(fa), .o_dq_out(dqo), .o_dq_oe_n(dq_oe_n), .i_dq_in(dqw), .o_ce_n(ce_n),
    .o_we_n(we_n), .o_oe_n(oe_n), .o_byte_n(byte_n), .o_flash_reset_n(frst_n),
    .i_ready_busy_out(rb));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) mdl (.i_addr(fa), .i_dq(dqw),
    .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_byte_n(byte_n), .i_reset_n(frst_n),
    .o_dq(dqm), .o_rb(rb));
  initial forever #50 i_clock = ~i_clock;
  task automatic end_of_test;
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [36:0] e, input logic [36:0] g);
    n_checks++;
    if (e !== g)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge i_clock);
    rw <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge i_clock);
    ra <= a;
    rr <= 1'b1;
    @(posedge i_clock);
    rr <= 1'b0;
    #1 v = rd;
  endtask
  task automatic cmd(input op_t op, input logic [20:0] a, input logic [15:0] d);
    wreg(`REG_ADDR, {11'h000, a});
    wreg(`REG_DATA, {16'h0000, d});
    wreg(`REG_CMD, {28'h000_0000, op});
  endtask
  // Polls status until idle in the wanted mode; the bound keeps a hang short.
  task automatic idle(input mode_t m);
    for (int i = 0; i < 300; i++)
    begin
      rreg(`REG_STATUS);
      if (v[0] === 1'b0 && v[7:4] === m) break;
    end
    chk("mode", m, v[7:4]);
  endtask
  task automatic refused(input op_t op);
    cmd(op, 21'h00_0012, 16'h0000);
    rreg(`REG_STATUS);
    chk("refused", 1'b1, v[2]);
    wreg(`REG_STATUS, 32'h0000_0004);
  endtask
  task automatic lg(input int i, input logic [15:0] d);
    chk("cycle data", d, mdl.log_q[i][15:0]);
  endtask
  task automatic t_reset;
    rreg(`REG_STATUS);
    chk("status", 32'h0000_0002, v);
    wreg(`REG_CTRL, 32'h0000_0002);
    repeat (210) @(posedge i_clock);
    idle(M_READ);
    chk("byte_n", 1'b1, byte_n);
  endtask
  task automatic t_prog;
    mdl.log_q.delete();
    cmd(OP_PROG, 21'h00_0012, 16'hA55A);
    idle(M_READ);
    chk("c0", {`UNLOCK1_WORD, 16'h00AA}, mdl.log_q[0]);
    chk("c1", {`UNLOCK2_WORD, 16'h0055}, mdl.log_q[1]);
    chk("c2", {`UNLOCK1_WORD, 16'h00A0}, mdl.log_q[2]);
    chk("c3", {21'h00_0012, 16'hA55A}, mdl.log_q[3]);
    cmd(OP_PROG, 21'h00_0012, 16'h0FF0);
    idle(M_READ);
    cmd(OP_READ, 21'h00_0012, 16'h0000);
    idle(M_READ);
    rreg(`REG_RDATA);
    chk("rdata", 32'h0000_0550, v);
  endtask
  task automatic t_id;
    cmd(OP_ID, 21'h00_0000, 16'h0000);
    idle(M_ID);
    rreg(`REG_RDATA);
    chk("maker", MFR, v);
    cmd(OP_READ, 21'h00_0001, 16'h0000);
    idle(M_ID);
    rreg(`REG_RDATA);
    chk("device", DEV, v);
    refused(OP_PROG);
    cmd(OP_RESET, 21'h00_0000, 16'h0000);
    idle(M_READ);
    lg(mdl.log_q.size() - 1, 16'h00F0);
    cmd(OP_CFI, 21'h00_0000, 16'h0000);
    idle(M_CFI);
    cmd(OP_RESET, 21'h00_0000, 16'h0000);
    idle(M_READ);
  endtask
  task automatic t_byp;
    mdl.log_q.delete();
    cmd(OP_BYP_ENTER, 21'h00_0000, 16'h0000);
    idle(M_BYPASS);
    lg(2, 16'h0020);
    refused(OP_PROG);
    cmd(OP_BYP_PROG, 21'h00_0020, 16'h1234);
    idle(M_BYPASS);
    lg(3, 16'h00A0);
    chk("pa", {21'h00_0020, 16'h1234}, mdl.log_q[4]);
    cmd(OP_BYP_EXIT, 21'h00_0000, 16'h0000);
    idle(M_READ);
    lg(5, 16'h0090);
    lg(6, 16'h0000);
  endtask
  task automatic t_erase;
    logic [15:0] ed [6];
    ed = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA, 16'h0055, 16'h0010};
    refused(OP_SUSPEND);
    refused(OP_RESUME);
    mdl.log_q.delete();
    cmd(OP_CHIP_ER, 21'h00_0000, 16'h0000);
    idle(M_READ);
    foreach (ed[i]) lg(i, ed[i]);
    mdl.log_q.delete();
    cmd(OP_SECT_ER, 21'h01_2000, 16'h0000);
    idle(M_READ);
    chk("sector", {21'h01_2000, 16'h0030}, mdl.log_q[5]);
    wreg(`REG_CTRL, 32'h0000_0001);
    mdl.log_q.delete();
    cmd(OP_RESET, 21'h00_0000, 16'h0000);
    idle(M_READ);
    chk("byte unlock", {`UNLOCK1_BYTE, 16'h00F0}, mdl.log_q[0]);
    chk("byte_n low", 1'b0, byte_n);
  endtask
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    // The ready/busy level needs two edges through its synchroniser.
    repeat (2) @(posedge i_clock);
    t_reset;
    t_prog;
    t_id;
    t_byp;
    t_erase;
    end_of_test;
  end
endmodule
`default_nettype wire
